// ---- psc_pkg.sv ----
// Shared constants and carrier types for the port statistics counters
package psc_pkg;
    localparam int PORTS = 12;
    localparam int NCNT  = 21;
    localparam int CNT_W = 32;
    localparam int LEN_W = 14;
    localparam int SEL_W = 4;
    localparam int TMR_W = 28;

    localparam logic [LEN_W-1:0] MIN_LEN  = 14'h0040;
    localparam logic [LEN_W-1:0] MAX_LEN  = 14'h05EE;
    localparam logic [LEN_W-1:0] LATE_OCT = 14'h0040;
    localparam logic [SEL_W-1:0] LAST_PORT = 4'hB;

    // Length bin bounds, inclusive
    localparam int NBIN = 6;
    localparam logic [LEN_W-1:0] BIN_LO [NBIN] =
        '{14'h0040, 14'h0041, 14'h0080, 14'h0100, 14'h0200, 14'h0400};
    localparam logic [LEN_W-1:0] BIN_HI [NBIN] =
        '{14'h0040, 14'h007F, 14'h00FF, 14'h01FF, 14'h03FF, 14'h05EE};

    // Counter slots
    localparam int C_RXERR = 0;
    localparam int C_CRC   = 1;
    localparam int C_OVR   = 2;
    localparam int C_FRAG  = 3;
    localparam int C_JAB   = 4;
    localparam int C_COL   = 5;
    localparam int C_LATE  = 6;
    localparam int C_BTX   = 7;
    localparam int C_BRX   = 8;
    localparam int C_OCT   = 9;
    localparam int C_MC    = 10;
    localparam int C_BC    = 11;
    localparam int C_RXG   = 12;
    localparam int C_TXG   = 13;
    localparam int C_BIN0  = 14;
    localparam int C_RXTOT = 20;

    // Rate interval: one second at a 4 ns clock
    localparam longint SEC_NS  = 1000000000;
    localparam longint CLK_NS  = 4;
    localparam int     SEC_CYC = int'(SEC_NS / CLK_NS);

    typedef logic [NCNT-1:0][CNT_W-1:0] psc_cnt_t;

    typedef struct packed {
        logic             valid;
        logic [LEN_W-1:0] len;
        logic             fcs_bad;
        logic             align_bad;
        logic             mac_err;
        logic             mcast;
        logic             bcast;
    } psc_rx_s;

    typedef struct packed {
        logic             valid;
        logic [LEN_W-1:0] len;
        logic             ok;
    } psc_tx_s;

    typedef struct packed {
        logic             valid;
        logic [LEN_W-1:0] octet;
    } psc_col_s;
endpackage

// ---- psc_stats.sv ----
// Per-port statistics counters with rate snapshot and port selection
`timescale 1ns/1ps
`default_nettype none
module psc_stats #(
    parameter logic [psc_pkg::TMR_W-1:0] P_SEC_CYC = psc_pkg::TMR_W'(psc_pkg::SEC_CYC)
) (
    // Clock and reset
    input  wire logic                                    i_sys_clk,
    input  wire logic                                    i_rst_n,
    // Frame status from each port's MAC
    input  wire psc_pkg::psc_rx_s  [psc_pkg::PORTS-1:0]  i_rx,
    input  wire psc_pkg::psc_tx_s  [psc_pkg::PORTS-1:0]  i_tx,
    input  wire psc_pkg::psc_col_s [psc_pkg::PORTS-1:0]  i_col,
    // Management commands
    input  wire logic                                    i_clear,
    input  wire logic                                    i_view_open,
    input  wire logic                                    i_select_previous_port,
    input  wire logic                                    i_select_following_port,
    input  wire logic                                    i_sel_valid,
    input  wire logic [psc_pkg::SEL_W-1:0]               i_sel_port,
    // Selected port view
    output logic [psc_pkg::SEL_W-1:0]                    o_port,
    output psc_pkg::psc_cnt_t                            o_cnt,
    output psc_pkg::psc_cnt_t                            o_rate
);
    import psc_pkg::*;

    typedef struct packed {
        logic [PORTS-1:0][NCNT-1:0][CNT_W-1:0] cnt;
        logic [PORTS-1:0][NCNT-1:0][CNT_W-1:0] acc;
        logic [PORTS-1:0][NCNT-1:0][CNT_W-1:0] rate;
        logic [TMR_W-1:0]                      timer;
        logic [SEL_W-1:0]                      sel;
        psc_cnt_t                              out_cnt;
        psc_cnt_t                              out_rate;
    } psc_state_s;

    psc_state_s                            st;
    psc_state_s                            next_st;
    logic [PORTS-1:0][NCNT-1:0][CNT_W-1:0] inc;
    logic                                  clr;
    logic                                  sec_tick;

    function automatic logic [CNT_W-1:0] one(input logic b);
        one = {{(CNT_W-1){1'b0}}, b};
    endfunction

    // View opening is a clear too, so the display starts from zero
    assign clr      = i_clear | i_view_open;
    assign sec_tick = (st.timer == P_SEC_CYC - 1'b1);

    // Per-port event decode, one increment per counter slot
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        logic rv;
        logic bad;
        logic too_short;
        logic too_long;
        logic good;
        logic tgood;
        assign rv        = i_rx[p].valid;
        assign bad       = i_rx[p].fcs_bad | i_rx[p].align_bad;
        assign too_short = i_rx[p].len < MIN_LEN;
        assign too_long  = i_rx[p].len > MAX_LEN;
        assign good      = rv & ~bad & ~too_short & ~too_long & ~i_rx[p].mac_err;
        assign tgood = i_tx[p].valid & i_tx[p].ok;

        assign inc[p][C_RXERR] = one(rv & i_rx[p].mac_err);
        // Well formed: right length, aligned, FCS wrong; the MAC error flag is not looked at
        assign inc[p][C_CRC]   = one(rv & i_rx[p].fcs_bad & ~i_rx[p].align_bad
                                     & ~too_short & ~too_long);
        assign inc[p][C_OVR]   = one(rv & too_long);
        assign inc[p][C_FRAG]  = one(rv & too_short & bad);
        assign inc[p][C_JAB]   = one(rv & too_long & bad);
        assign inc[p][C_COL]   = one(i_col[p].valid);
        assign inc[p][C_LATE]  = one(i_col[p].valid & (i_col[p].octet >= LATE_OCT));
        assign inc[p][C_BTX]   = tgood ? CNT_W'(i_tx[p].len) : '0;
        assign inc[p][C_BRX]   = good ? CNT_W'(i_rx[p].len) : '0;
        assign inc[p][C_OCT]   = rv ? CNT_W'(i_rx[p].len) : '0;
        assign inc[p][C_MC]    = one(good & i_rx[p].mcast);
        assign inc[p][C_BC]    = one(good & i_rx[p].bcast);
        assign inc[p][C_RXG]   = one(good);
        assign inc[p][C_TXG]   = one(tgood);
        assign inc[p][C_RXTOT] = one(rv);

        // Frames above 1518 octets fall in no bin
        for (genvar k = 0; k < NBIN; k++)
        begin : g_bin
            assign inc[p][C_BIN0+k] = one(rv & (i_rx[p].len >= BIN_LO[k])
                                          & (i_rx[p].len <= BIN_HI[k]));
        end
    end

    always_comb
    begin
        next_st       = st;
        next_st.timer = sec_tick ? '0 : st.timer + 1'b1;
        for (int p = 0; p < PORTS; p++)
        begin
            for (int c = 0; c < NCNT; c++)
            begin
                if (clr)
                begin
                    // Clear wins over a same-cycle event
                    next_st.cnt[p][c]  = '0;
                    next_st.acc[p][c]  = '0;
                    next_st.rate[p][c] = '0;
                end
                else
                begin
                    // Plain modulo add wraps at 32 bits
                    next_st.cnt[p][c] = st.cnt[p][c] + inc[p][c];
                    if (sec_tick)
                    begin
                        next_st.rate[p][c] = st.acc[p][c] + inc[p][c];
                        next_st.acc[p][c]  = '0;
                    end
                    else
                    begin
                        next_st.acc[p][c] = st.acc[p][c] + inc[p][c];
                    end
                end
            end
        end
        if (i_sel_valid && (i_sel_port <= LAST_PORT))
        begin
            next_st.sel = i_sel_port;
        end
        else if (i_select_previous_port)
        begin
            next_st.sel = (st.sel == '0) ? LAST_PORT : st.sel - 1'b1;
        end
        else if (i_select_following_port)
        begin
            next_st.sel = (st.sel == LAST_PORT) ? '0 : st.sel + 1'b1;
        end
        // Wide mux registered so outputs come from flops, same cycle as counters
        next_st.out_cnt  = next_st.cnt[next_st.sel];
        next_st.out_rate = next_st.rate[next_st.sel];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_port = st.sel;
    assign o_cnt  = st.out_cnt;
    assign o_rate = st.out_rate;

    // Checks on port 0 slots, plus clear, port 1 isolation and port select wrap
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    property p_step(en, int c, logic [CNT_W-1:0] amt);
        !clr && en |=> st.cnt[0][c] == $past(st.cnt[0][c]) + amt;
    endproperty

    a_rx_err:   assert property (p_step(i_rx[0].valid && i_rx[0].mac_err, C_RXERR, 1))
        else $error("rx error count did not step");
    a_crc_err:  assert property (p_step(i_rx[0].valid && i_rx[0].fcs_bad
        && !i_rx[0].align_bad && i_rx[0].len == 14'h0100, C_CRC, 1))
        else $error("crc count did not step");
    a_oversize: assert property (p_step(i_rx[0].valid
        && i_rx[0].len == 14'h05EF, C_OVR, 1))
        else $error("oversize count did not step");
    a_frag_cnt: assert property (p_step(i_rx[0].valid && i_rx[0].len == 14'h003F
        && i_rx[0].fcs_bad, C_FRAG, 1))
        else $error("fragment count did not step");
    a_jab_cnt:  assert property (p_step(i_rx[0].valid && i_rx[0].len > MAX_LEN
        && i_rx[0].align_bad, C_JAB, 1))
        else $error("jabber count did not step");
    a_col_cnt:  assert property (p_step(i_col[0].valid, C_COL, 1))
        else $error("collision count did not step");
    a_late_col: assert property (p_step(i_col[0].valid
        && i_col[0].octet == 14'h003F, C_LATE, 0))
        else $error("collision before octet 64 counted late");
    a_tx_bytes: assert property (p_step(i_tx[0].valid && i_tx[0].ok, C_BTX,
        CNT_W'($past(i_tx[0].len))))
        else $error("tx bytes wrong");
    a_rx_bytes: assert property (p_step(i_rx[0].valid && i_rx[0].fcs_bad, C_BRX, 0))
        else $error("bad frame added to good rx bytes");
    a_tot_octs: assert property (p_step(i_rx[0].valid, C_OCT,
        CNT_W'($past(i_rx[0].len))))
        else $error("total octets wrong");
    a_mc_cnt:   assert property (p_step(i_rx[0].valid && i_rx[0].mcast
        && i_rx[0].fcs_bad, C_MC, 0))
        else $error("bad multicast counted");
    a_bc_cnt:   assert property (p_step(i_rx[0].valid && i_rx[0].bcast
        && !i_rx[0].fcs_bad && !i_rx[0].align_bad && !i_rx[0].mac_err
        && i_rx[0].len == 14'h0040, C_BC, 1))
        else $error("good broadcast missed");
    a_rx_good:  assert property (p_step(i_rx[0].valid && i_rx[0].len == 14'h05EE
        && !i_rx[0].fcs_bad && !i_rx[0].align_bad && !i_rx[0].mac_err, C_RXG, 1))
        else $error("good frame missed");
    a_tx_good:  assert property (p_step(i_tx[0].valid && !i_tx[0].ok, C_TXG, 0))
        else $error("failed tx counted good");
    a_bin_mid:  assert property (p_step(i_rx[0].valid
        && i_rx[0].len == 14'h007F, C_BIN0 + 1, 1))
        else $error("65-127 bin did not step");
    a_bin_top:  assert property (p_step(i_rx[0].valid
        && i_rx[0].len == MAX_LEN, C_BIN0 + 5, 1))
        else $error("1024-1518 bin did not step");
    a_bin_none: assert property (p_step(i_rx[0].valid
        && i_rx[0].len > MAX_LEN, C_BIN0 + 5, 0))
        else $error("oversize frame counted in a bin");
    a_rx_total: assert property (p_step(i_rx[0].valid, C_RXTOT, 1))
        else $error("total rx frames did not step");
    a_clear_all: assert property (clr |=> st.cnt == '0 && o_cnt == '0)
        else $error("clear left a counter nonzero");
    a_rate_clr: assert property (clr
        |=> st.rate == '0 && st.acc == '0 && o_rate == '0)
        else $error("clear left a rate nonzero");
    a_port_iso: assert property (!clr && !i_rx[1].valid
        |=> st.cnt[1][C_RXTOT] == $past(st.cnt[1][C_RXTOT]))
        else $error("port 1 counted without a frame");
    a_sel_wrap: assert property (!i_sel_valid && !i_select_previous_port
        && i_select_following_port && o_port == LAST_PORT |=> o_port == '0)
        else $error("port select did not wrap");
    a_rate_snap: assert property (sec_tick && !clr && !i_rx[0].valid
        |=> st.rate[0][C_RXTOT] == $past(st.acc[0][C_RXTOT]) && st.acc[0][C_RXTOT] == '0)
        else $error("rate snapshot wrong");

    c_clear:    cover property (clr ##1 i_rx[0].valid);
    c_tick:     cover property (sec_tick && st.acc[0][C_RXTOT] != '0);
    c_jabber:   cover property (inc[0][C_JAB] != '0);
    c_sel_prev: cover property (i_select_previous_port && o_port == '0);
endmodule
`default_nettype wire

// ---- psc_mac_model.sv ----
// MAC frame status model driving per-port event pulses
`timescale 1ns/1ps
`default_nettype none
module psc_mac_model (
    // Clock
    input  wire logic                                   i_sys_clk,
    // Event pulses towards the statistics block
    output var  psc_pkg::psc_rx_s  [psc_pkg::PORTS-1:0] o_rx,
    output var  psc_pkg::psc_tx_s  [psc_pkg::PORTS-1:0] o_tx,
    output var  psc_pkg::psc_col_s [psc_pkg::PORTS-1:0] o_col
);
    import psc_pkg::*;

    initial
    begin
        o_rx  = '0;
        o_tx  = '0;
        o_col = '0;
    end

    // Released fields show inverted data, so stale values never look valid
    task automatic send_rx(input int p, input logic [LEN_W-1:0] l, input logic [4:0] fl);
        @(negedge i_sys_clk);
        o_rx[p] = {1'b1, l, fl};
        @(negedge i_sys_clk);
        o_rx[p] = {1'b0, ~l, ~fl};
    endtask

    task automatic send_tx(input int p, input logic [LEN_W-1:0] l, input logic ok);
        @(negedge i_sys_clk);
        o_tx[p] = {1'b1, l, ok};
        @(negedge i_sys_clk);
        o_tx[p] = {1'b0, ~l, ~ok};
    endtask

    task automatic send_col(input int p, input logic [LEN_W-1:0] oct);
        @(negedge i_sys_clk);
        o_col[p] = {1'b1, oct};
        @(negedge i_sys_clk);
        o_col[p] = {1'b0, ~oct};
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the port statistics counters
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psc_pkg::*;
    // Short rate interval keeps the timer moving in a short run
    localparam logic [TMR_W-1:0] RATE_CYC = 28'h000_0010;
    logic                 sys_clk = 1'b0;
    logic                 rst_n   = 1'b0;
    logic                 clr     = 1'b0;
    logic                 view    = 1'b0;
    logic                 prv     = 1'b0;
    logic                 fol     = 1'b0;
    logic                 sel_v   = 1'b0;
    logic [SEL_W-1:0]     sel_p   = '0;
    psc_rx_s  [PORTS-1:0] rx;
    psc_tx_s  [PORTS-1:0] tx;
    psc_col_s [PORTS-1:0] col;
    logic [SEL_W-1:0]     port;
    psc_cnt_t             cnt;
    psc_cnt_t             rate;
    int                   cyc = 0;
    logic [CNT_W-1:0]     exp_cnt [PORTS][NCNT];
    logic [31:0]          lfsr = 32'h8e2b_b6be;
    logic [31:0]          r;
    int                   err_total = 0;
    int                   cmp_count = 0;
    int                   lens [11] = '{63, 64, 65, 127, 128, 255, 256, 1023, 1024, 1518, 1519};
    logic [4:0]           flags [6] = '{5'h02, 5'h10, 5'h09, 5'h04, 5'h12, 5'h01};

    always #2 sys_clk = ~sys_clk;

    // Edges since reset release, in step with the rate timer
    always @(posedge sys_clk) cyc <= rst_n ? cyc + 1 : 0;

    psc_mac_model i_mac (.i_sys_clk(sys_clk), .o_rx(rx), .o_tx(tx), .o_col(col));

    psc_stats #(.P_SEC_CYC(RATE_CYC)) i_dut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_rx(rx), .i_tx(tx), .i_col(col),
        .i_clear(clr), .i_view_open(view), .i_select_previous_port(prv),
        .i_select_following_port(fol), .i_sel_valid(sel_v), .i_sel_port(sel_p),
        .o_port(port), .o_cnt(cnt), .o_rate(rate)
    );

    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic void clear_exp();
        foreach (exp_cnt[i, j]) exp_cnt[i][j] = '0;
    endfunction

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic do_rx(input int p, input int l, input logic [4:0] fl);
        logic good;
        logic bad;
        good = (fl[4:2] == 3'b000) && l >= 64 && l <= 1518;
        bad  = fl[4] || fl[3];
        exp_cnt[p][C_RXTOT]++;
        exp_cnt[p][C_OCT] += l;
        if (fl[2]) exp_cnt[p][C_RXERR]++;
        if (fl[4] && !fl[3] && l >= 64 && l <= 1518) exp_cnt[p][C_CRC]++;
        if (l > 1518) exp_cnt[p][C_OVR]++;
        if (l < 64 && bad) exp_cnt[p][C_FRAG]++;
        if (l > 1518 && bad) exp_cnt[p][C_JAB]++;
        if (good)
        begin
            exp_cnt[p][C_BRX] += l;
            exp_cnt[p][C_RXG]++;
            if (fl[1]) exp_cnt[p][C_MC]++;
            if (fl[0]) exp_cnt[p][C_BC]++;
        end
        for (int b = 0; b < NBIN; b++)
            if (l >= BIN_LO[b] && l <= BIN_HI[b]) exp_cnt[p][C_BIN0 + b]++;
        i_mac.send_rx(p, LEN_W'(l), fl);
    endtask

    task automatic do_tx(input int p, input int l, input logic ok);
        if (ok) exp_cnt[p][C_TXG]++;
        if (ok) exp_cnt[p][C_BTX] += l;
        i_mac.send_tx(p, LEN_W'(l), ok);
    endtask

    task automatic do_col(input int p, input int oct);
        exp_cnt[p][C_COL]++;
        if (oct >= 64) exp_cnt[p][C_LATE]++;
        i_mac.send_col(p, LEN_W'(oct));
    endtask

    task automatic chk_port(input int p);
        @(negedge sys_clk);
        sel_v = 1'b1;
        sel_p = SEL_W'(p);
        @(negedge sys_clk);
        sel_v = 1'b0;
        cmp("port", 32'(p), 32'(port));
        for (int s = 0; s < NCNT; s++)
            cmp($sformatf("port %0d slot %0d", p, s), exp_cnt[p][s], cnt[s]);
    endtask

    // Frames land inside one rate interval, read just after its closing tick
    task automatic chk_rate(input int p);
        logic [CNT_W-1:0] base [NCNT];
        chk_port(p);
        while (cyc % RATE_CYC != 0) @(negedge sys_clk);
        foreach (base[s]) base[s] = exp_cnt[p][s];
        do_rx(p, 200, 5'h02);
        do_tx(p, 300, 1'b1);
        do_col(p, 70);
        while (cyc % RATE_CYC != 0) @(negedge sys_clk);
        for (int s = 0; s < NCNT; s++)
            cmp($sformatf("rate %0d slot %0d", p, s), exp_cnt[p][s] - base[s], rate[s]);
    endtask

    // Steps the selection one place and checks the wrapped index
    task automatic step(input logic back, input int e);
        @(negedge sys_clk);
        prv = back;
        fol = !back;
        @(negedge sys_clk);
        prv = 1'b0;
        fol = 1'b0;
        cmp("stepped port", 32'(e), 32'(port));
    endtask

    // Clear pulse lands in the same cycle as a frame on port p
    task automatic clear_with_frame(input int p, input logic by_view);
        fork
            do_rx(p, 100, 5'h00);
            begin
                @(negedge sys_clk);
                if (by_view) view = 1'b1;
                else clr = 1'b1;
                @(negedge sys_clk);
                view = 1'b0;
                clr  = 1'b0;
            end
        join
        clear_exp();
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #40000;
        err_total++;
        give_verdict();
    end

    initial
    begin
        clear_exp();
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        chk_port(0);
        // Corner frames go to port 0, where the assertions watch
        foreach (lens[i])
            foreach (flags[k])
                do_rx(0, lens[i], flags[k]);
        do_tx(0, 100, 1'b1);
        do_tx(0, 200, 1'b0);
        do_col(0, 63);
        do_col(0, 64);
        chk_port(0);
        for (int n = 0; n < 80; n++)
        begin
            r = next_rand();
            case (r[31:30])
                2'd0: do_tx(r[27:24] % PORTS, r[13:0] % 1600, r[29]);
                2'd1: do_col(r[27:24] % PORTS, r[13:0] % 1600);
                default: do_rx(r[27:24] % PORTS, r[13:0] % 1600, r[4:0] & r[9:5]);
            endcase
        end
        for (int p = 0; p < PORTS; p++)
            chk_port(p);
        clear_with_frame(5, 1'b0);
        chk_port(5);
        chk_port(3);
        do_rx(5, 64, 5'h01);
        clear_with_frame(5, 1'b1);
        chk_port(5);
        do_rx(5, 1518, 5'h02);
        chk_port(5);
        chk_rate(5);
        chk_port(0);
        step(1'b1, 11);
        step(1'b0, 0);
        step(1'b0, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
